// ### rtl/dma_cfg.svh
// named offsets, field positions and encodings of the four-channel dma
// assumes inclusion by bare name from the package and the design modules
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

`define NUM_CH          4
`define NUM_PERIPH      5
`define SEL_W           4
`define SEL_NONE        4'hF
`define CTRL_W          14
`define IRQ_W           4

// word index of each register inside a channel window of 0x20 bytes
`define OFF_SRC         3'h0
`define OFF_DST         3'h1
`define OFF_LEN         3'h2
`define OFF_THR         3'h3
`define OFF_CTRL        3'h4
`define OFF_IDX         3'h5

// global registers, byte addresses
`define ADDR_ROUTE      8'h80
`define ADDR_ISTAT      8'h84
`define ADDR_FRZ_SET    8'h88
`define ADDR_FRZ_CLR    8'h8C
`define ADDR_FRZ_STAT   8'h90

`define GLOBAL_BIT      7
`define FRZ_BIT         4
`define HTRANS_ACT_BIT  1
`define BW_32           2'h2
`define RD_ZERO         32'h0000_0000

`endif

// ### rtl/dma_pkg.sv
// types shared by the dma controller modules
// assumes dma_cfg.svh for the widths it names
`include "dma_cfg.svh"

package dma_pkg;

   typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_e;

   typedef struct packed {
      logic       irq_allow;
      logic       fill_lock;
      logic       yield;
      logic [2:0] channel_priority;
      logic       wrap_mode;
      logic       edge_sense;
      logic       request_trigger_select;
      logic       dest_increment;
      logic       source_increment;
      logic [1:0] bus_width_select;
      logic       channel_on;
   } chan_ctrl_s;

   typedef struct packed {
      logic [31:0] source_base;
      logic [31:0] dest_base;
      logic [15:0] transfer_length;
      logic [15:0] interrupt_threshold;
      logic [15:0] transfer_index;
      chan_ctrl_s  channel_control;
      logic        running;
      logic        blocked;
      logic        edge_pend;
      logic        req_prev;
      logic        irq_stat;
   } chan_s;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_s;

   typedef struct packed {
      logic       act;
      logic       wr;
      logic [7:0] addr;
   } ahb_s;

   typedef struct packed {
      chan_s [`NUM_CH-1:0]     ch;
      logic [2*`SEL_W-1:0]     request_route;
      logic                    freeze_channels;
      eng_e                    st;
      logic [1:0]              cur;
      mem_s                    mem;
      logic [`NUM_CH-1:0]      irq;
      logic [`NUM_PERIPH-1:0]  rx_ack;
      logic [`NUM_PERIPH-1:0]  tx_ack;
      ahb_s                    ahb;
      logic [31:0]             hrdata;
      logic                    hready;
      logic                    hresp;
   } top_s;

endpackage

// ### rtl/dma_request_router.sv
// routes peripheral requests onto channel pairs and acknowledges back
// assumes requests come from logic on the same clock as the dma
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"

module dma_request_router
   import dma_pkg::*;
(
   input  wire logic [2*`SEL_W-1:0]    pair_request_select,
   input  wire logic [`NUM_PERIPH-1:0] periph_rx_req,
   input  wire logic [`NUM_PERIPH-1:0] periph_tx_req,
   input  wire logic [`NUM_CH-1:0]     chan_ack,
   output logic      [`NUM_CH-1:0]     chan_req,
   output logic      [`NUM_PERIPH-1:0] periph_rx_ack,
   output logic      [`NUM_PERIPH-1:0] periph_tx_ack
);

   logic [`SEL_W-1:0] sel0;
   logic [`SEL_W-1:0] sel1;
   logic              ok0;
   logic              ok1;

   always_comb begin
      sel0 = pair_request_select[`SEL_W-1:0];
      sel1 = pair_request_select[2*`SEL_W-1:`SEL_W];
      if (sel1 == sel0) begin
         sel1 = `SEL_NONE;
      end
      ok0 = (sel0 < `SEL_W'(`NUM_PERIPH));
      ok1 = (sel1 < `SEL_W'(`NUM_PERIPH));
      chan_req      = '0;
      periph_rx_ack = '0;
      periph_tx_ack = '0;
      // rx to x, tx to y
      if (ok0) begin
         chan_req[0]             = periph_rx_req[sel0[2:0]];
         chan_req[1]             = periph_tx_req[sel0[2:0]];
         periph_rx_ack[sel0[2:0]] = chan_ack[0];
         periph_tx_ack[sel0[2:0]] = chan_ack[1];
      end
      if (ok1) begin
         chan_req[2]             = periph_rx_req[sel1[2:0]];
         chan_req[3]             = periph_tx_req[sel1[2:0]];
         periph_rx_ack[sel1[2:0]] = chan_ack[2];
         periph_tx_ack[sel1[2:0]] = chan_ack[3];
      end
   end

endmodule // dma_request_router
`default_nettype wire

// ### rtl/dma_priority_arbiter.sv
// picks the wanting channel of highest priority, lowest index on ties
// assumes want and priority are stable within the cycle
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"

module dma_priority_arbiter
   import dma_pkg::*;
(
   input  wire logic [`NUM_CH-1:0]      want,
   input  wire logic [`NUM_CH-1:0][2:0] prio,
   output logic                         grant_valid,
   output logic      [1:0]              grant_ch,
   output logic      [2:0]              grant_prio
);

   always_comb begin
      grant_valid = 1'b0;
      grant_ch    = 2'h0;
      grant_prio  = 3'h0;
      for (int i = 0; i < `NUM_CH; i++) begin
         if (want[i] && (!grant_valid || prio[i] > grant_prio)) begin
            grant_valid = 1'b1;
            grant_ch    = 2'(i);
            grant_prio  = prio[i];
         end
      end
   end

endmodule // dma_priority_arbiter
`default_nettype wire

// ### rtl/dma_controller.sv
// four-channel dma controller: ahb-lite register slave, one shared mover
// assumes a single-cycle-or-more memory port acked on the same clock and
// peripheral requests from logic on hclk

`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"

// What this block does
// - four channels moving 8, 16 or 32 bit items
// - selected peripheral tx request drives channel y, rx drives channel x
// - duplicate selector values: only the lower field is honoured
// - channel runs while on bit set; cleared by hardware at completion
// - trigger select 0 starts at once, 1 waits for peripheral request
// - level requests by default; edge mode starts one cycle per rising edge
// - read source base, write destination base, programmed length and width
// - sixteen bit index cleared at start, compared to length each item
// - address equals base plus index times increment times width
// - continue while start holds; stop at length or software trigger
// - on stop clear on bit unless hardware triggered with wrap
// - level-mode handshake channel blocked after each cycle until peripheral drops its request
// - wrap with hardware trigger clears index and restarts from bases
// - software triggered channel always stops at its length
// - index equal threshold raises interrupt after item, before increment
// - highest three bit priority wins; ties by fixed channel order
// - software channel with yield gives bus to higher priority requester
// - fill lock holds bus until transfer done, even with yield
// - bit 4 of freeze set freezes all; freeze clear releases them
// - freeze waits for running software memory transfer to finish
module dma_controller
   import dma_pkg::*;
(
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic                         mem_req,
   output logic                         mem_we,
   output logic      [1:0]              mem_size,
   output logic      [31:0]             mem_addr,
   output logic      [31:0]             mem_wdata,
   input  wire logic [31:0]             mem_rdata,
   input  wire logic                    mem_ack,
   input  wire logic [`NUM_PERIPH-1:0]  periph_rx_req,
   input  wire logic [`NUM_PERIPH-1:0]  periph_tx_req,
   output logic      [`NUM_PERIPH-1:0]  periph_rx_ack,
   output logic      [`NUM_PERIPH-1:0]  periph_tx_ack,
   output logic      [`NUM_CH-1:0]      dma_irq
);

   // ************************************************************
   // helpers
   // ************************************************************

   function automatic logic [31:0] item_addr(
      input logic [31:0] base,
      input logic [15:0] idx,
      input logic        inc,
      input logic [1:0]  bw
   );
      logic [1:0]  sh;
      logic [31:0] off;
      sh  = (bw > `BW_32) ? `BW_32 : bw;
      off = {16'h0000, idx} << sh;
      item_addr = inc ? (base + off) : base;
   endfunction

   function automatic logic [31:0] reg_read(
      input top_s       s,
      input logic [7:0] a
   );
      chan_s c;
      c = s.ch[a[6:5]];
      reg_read = `RD_ZERO;
      if (a[`GLOBAL_BIT]) begin
         case (a)
            `ADDR_ROUTE:    reg_read[2*`SEL_W-1:0] = s.request_route;
            `ADDR_ISTAT: begin
               for (int i = 0; i < `NUM_CH; i++) begin
                  reg_read[i] = s.ch[i].irq_stat;
               end
            end
            `ADDR_FRZ_STAT: reg_read[`FRZ_BIT] = s.freeze_channels;
            default:        reg_read = `RD_ZERO;
         endcase
      end else begin
         case (a[4:2])
            `OFF_SRC:  reg_read = c.source_base;
            `OFF_DST:  reg_read = c.dest_base;
            `OFF_LEN:  reg_read[15:0] = c.transfer_length;
            `OFF_THR:  reg_read[15:0] = c.interrupt_threshold;
            `OFF_CTRL: reg_read[`CTRL_W-1:0] = c.channel_control;
            `OFF_IDX:  reg_read[15:0] = c.transfer_index;
            default:   reg_read = `RD_ZERO;
         endcase
      end
   endfunction

   // ************************************************************
   // state, router and arbiter
   // ************************************************************

   // four channel records in one state
   top_s                     s_q;
   top_s                     s_d;
   logic [`NUM_CH-1:0]       chan_req;
   logic [`NUM_CH-1:0]       chan_ack;
   logic [`NUM_PERIPH-1:0]   rx_ack_c;
   logic [`NUM_PERIPH-1:0]   tx_ack_c;
   logic [`NUM_CH-1:0]       want;
   logic [`NUM_CH-1:0][2:0]  prio;
   logic                     win_valid;
   logic [1:0]               win_ch;
   logic [2:0]               win_prio;

   dma_request_router u_router (
      .pair_request_select (s_q.request_route),
      .periph_rx_req       (periph_rx_req),
      .periph_tx_req       (periph_tx_req),
      .chan_ack            (chan_ack),
      .chan_req            (chan_req),
      .periph_rx_ack       (rx_ack_c),
      .periph_tx_ack       (tx_ack_c)
   );

   always_comb begin
      for (int i = 0; i < `NUM_CH; i++) begin
         chan_ctrl_s k;
         logic       hw_ok;
         k     = s_q.ch[i].channel_control;
         // software start at once, hardware waits for request
         // edge mode uses a pending edge, level mode the line
         // level channel stays blocked until request drops
         hw_ok = k.edge_sense ? s_q.ch[i].edge_pend
                              : (chan_req[i] && !s_q.ch[i].blocked);
         // frozen software channel in progress still runs
         // others drop out only between items
         want[i] = k.channel_on && s_q.ch[i].running &&
                   (!k.request_trigger_select || hw_ok) &&
                   (!s_q.freeze_channels ||
                    (!k.request_trigger_select && s_q.ch[i].transfer_index
                     != 16'h0000));
         prio[i] = k.channel_priority;
      end
   end

   dma_priority_arbiter u_arb (
      .want        (want),
      .prio        (prio),
      .grant_valid (win_valid),
      .grant_ch    (win_ch),
      .grant_prio  (win_prio)
   );

   // ************************************************************
   // next state
   // ************************************************************

   always_comb begin
      logic [1:0]  wc;
      logic [1:0]  g;
      logic        go;
      logic        hold;
      chan_s       cc;
      chan_ctrl_s  ck;
      wc   = 2'h0;
      g    = 2'h0;
      go   = 1'b0;
      hold = 1'b0;
      cc   = s_q.ch[s_q.cur];
      ck   = cc.channel_control;
      s_d      = s_q;
      chan_ack = '0;

      // bus address phase; read data ready for the data phase
      s_d.ahb.act  = hsel && htrans[`HTRANS_ACT_BIT] && hready;
      s_d.ahb.wr   = hwrite;
      s_d.ahb.addr = haddr[7:0];
      if (s_d.ahb.act && !hwrite) begin
         s_d.hrdata = reg_read(s_q, haddr[7:0]);
      end

      // bus data phase write
      if (s_q.ahb.act && s_q.ahb.wr) begin
         wc = s_q.ahb.addr[6:5];
         if (s_q.ahb.addr[`GLOBAL_BIT]) begin
            case (s_q.ahb.addr)
               `ADDR_ROUTE: s_d.request_route = hwdata[2*`SEL_W-1:0];
               `ADDR_ISTAT: begin
                  // write one to clear a flag
                  for (int i = 0; i < `NUM_CH; i++) begin
                     if (hwdata[i]) begin
                        s_d.ch[i].irq_stat = 1'b0;
                     end
                  end
               end
               // freeze set and clear, one bit each
               `ADDR_FRZ_SET: s_d.freeze_channels |= hwdata[`FRZ_BIT];
               `ADDR_FRZ_CLR: s_d.freeze_channels &= !hwdata[`FRZ_BIT];
               default: ;
            endcase
         end else begin
            case (s_q.ahb.addr[4:2])
               `OFF_SRC:  s_d.ch[wc].source_base = hwdata;
               `OFF_DST:  s_d.ch[wc].dest_base = hwdata;
               `OFF_LEN:  s_d.ch[wc].transfer_length = hwdata[15:0];
               `OFF_THR:  s_d.ch[wc].interrupt_threshold = hwdata[15:0];
               `OFF_CTRL: s_d.ch[wc].channel_control = hwdata[`CTRL_W-1:0];
               default: ;
            endcase
         end
      end

      // per-channel bookkeeping
      for (int i = 0; i < `NUM_CH; i++) begin
         // index cleared when the transfer starts
         if (s_q.ch[i].channel_control.channel_on && !s_q.ch[i].running) begin
            s_d.ch[i].running        = 1'b1;
            s_d.ch[i].transfer_index = 16'h0000;
         end
         if (!s_d.ch[i].channel_control.channel_on &&
             !(s_q.st != ENG_IDLE && s_q.cur == 2'(i))) begin
            s_d.ch[i].running = 1'b0;
         end
         // released once the request line drops
         if (s_q.ch[i].blocked && !chan_req[i]) begin
            s_d.ch[i].blocked = 1'b0;
         end
         s_d.ch[i].req_prev = chan_req[i];
      end

      // shared mover
      case (s_q.st)
         ENG_IDLE: begin
            // fill lock keeps the bus with the current channel
            // yield lets only a strictly higher priority in
            hold = cc.running && ck.channel_on &&
                   (ck.fill_lock ||
                    (!ck.request_trigger_select && !ck.yield &&
                     cc.transfer_index != 16'h0000));
            if (hold) begin
               go = want[s_q.cur];
               g  = s_q.cur;
            end else if (win_valid) begin
               go = 1'b1;
               g  = win_ch;
               if (want[s_q.cur] && cc.transfer_index != 16'h0000 &&
                   !ck.request_trigger_select && win_prio <=
                   ck.channel_priority) begin
                  g = s_q.cur;
               end
            end
            if (go) begin
               cc  = s_q.ch[g];
               ck  = cc.channel_control;
               s_d.cur = g;
               s_d.ch[g].edge_pend = 1'b0;
               s_d.mem.req  = 1'b1;
               s_d.mem.we   = 1'b0;
               s_d.mem.size = ck.bus_width_select;
               s_d.mem.addr = item_addr(cc.source_base, cc.transfer_index,
                                        ck.source_increment,
                                        ck.bus_width_select);
               s_d.st = ENG_READ;
            end
         end
         ENG_READ: begin
            if (mem_ack) begin
               s_d.mem.we    = 1'b1;
               s_d.mem.wdata = mem_rdata;
               s_d.mem.addr  = item_addr(cc.dest_base, cc.transfer_index,
                                         ck.dest_increment,
                                         ck.bus_width_select);
               s_d.st = ENG_WRITE;
            end
         end
         ENG_WRITE: begin
            if (mem_ack) begin
               s_d.mem.req = 1'b0;
               s_d.mem.we  = 1'b0;
               s_d.st      = ENG_IDLE;
               // interrupt before the index moves on
               if (cc.transfer_index == cc.interrupt_threshold) begin
                  s_d.ch[s_q.cur].irq_stat = 1'b1;
               end
               if (ck.request_trigger_select) begin
                  chan_ack[s_q.cur] = 1'b1;
                  // in level mode, wait for the peripheral to drop its request
                  s_d.ch[s_q.cur].blocked = !ck.edge_sense;
               end
               // stop at length, else next item
               if (cc.transfer_index == cc.transfer_length) begin
                  // clear on bit unless hardware wrap
                  if (!ck.request_trigger_select || !ck.wrap_mode) begin
                     s_d.ch[s_q.cur].channel_control.channel_on = 1'b0;
                     s_d.ch[s_q.cur].running = 1'b0;
                  end else begin
                     s_d.ch[s_q.cur].transfer_index = 16'h0000;
                  end
               end else begin
                  s_d.ch[s_q.cur].transfer_index = cc.transfer_index +
                                                   16'h0001;
               end
            end
         end
         default: s_d.st = ENG_IDLE;
      endcase

      // rising edge latched after consumption so none is lost
      for (int i = 0; i < `NUM_CH; i++) begin
         if (chan_req[i] && !s_q.ch[i].req_prev) begin
            s_d.ch[i].edge_pend = 1'b1;
         end
         s_d.irq[i] = s_d.ch[i].irq_stat &&
                      s_d.ch[i].channel_control.irq_allow;
      end
      // acknowledges go back through the router
      s_d.rx_ack = rx_ack_c;
      s_d.tx_ack = tx_ack_c;
   end

   // ************************************************************
   // registers and outputs
   // ************************************************************

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q               <= '0;
         s_q.request_route <= {`SEL_NONE, `SEL_NONE};
         s_q.hready        <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata        = s_q.hrdata;
   assign hreadyout     = s_q.hready;
   assign hresp         = s_q.hresp;
   assign mem_req       = s_q.mem.req;
   assign mem_we        = s_q.mem.we;
   assign mem_size      = s_q.mem.size;
   assign mem_addr      = s_q.mem.addr;
   assign mem_wdata     = s_q.mem.wdata;
   assign periph_rx_ack = s_q.rx_ack;
   assign periph_tx_ack = s_q.tx_ack;
   assign dma_irq       = s_q.irq;

endmodule // dma_controller
`default_nettype wire

// ### tb/dma_checker.sv
// assertions on the dma mover and register bus ports
// assumes a bind onto dma_controller, one hclk domain
`timescale 1ns/10ps
`default_nettype none
`include "dma_cfg.svh"
module dma_checker (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hreadyout,
   input wire logic                   hresp,
   input wire logic                   mem_req,
   input wire logic                   mem_we,
   input wire logic                   mem_ack,
   input wire logic [31:0]            mem_addr,
   input wire logic [31:0]            mem_wdata,
   input wire logic [31:0]            mem_rdata,
   input wire logic [`NUM_PERIPH-1:0] periph_rx_ack,
   input wire logic [`NUM_PERIPH-1:0] periph_tx_ack
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_done; mem_req && !mem_we && mem_ack; endsequence
   sequence wr_done; mem_req && mem_we && mem_ack; endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   a_req_holds: assert property (mem_req && !mem_ack |=> mem_req)
      else $error("request dropped before ack");
   a_addr_holds: assert property (mem_req && !mem_ack |=>
      $stable(mem_addr)) else $error("address moved while waiting");
   a_read_write: assert property (rd_done |=> mem_req && mem_we)
      else $error("read not followed by write");
   a_copy_word: assert property (rd_done |=>
      mem_wdata == $past(mem_rdata))
      else $error("write data differs from read word");
   a_item_ends: assert property (wr_done |=> !mem_req)
      else $error("request after item write");
   a_ack_cause: assert property ((|periph_rx_ack) || (|periph_tx_ack)
      |-> $past(mem_ack && mem_we)) else $error("ack without write");
   a_one_ack: assert property (
      $onehot0({periph_rx_ack, periph_tx_ack}))
      else $error("more than one peripheral ack");
endmodule // dma_checker
bind dma_controller dma_checker chk_u (.hclk, .hresetn, .hreadyout, .hresp,
   .mem_req, .mem_we, .mem_ack, .mem_addr, .mem_wdata, .mem_rdata,
   .periph_rx_ack, .periph_tx_ack);
`default_nettype wire

// ### tb/mem_model.sv
// memory on the far side of the mover port, logs every write
// assumes mem_req is held until mem_ack, same clock
`timescale 1ns/10ps
`default_nettype none
module mem_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata,
   output logic      [15:0] wr_n,
   output logic      [31:0] last_a,
   output logic      [31:0] last_d
);
   logic [1:0] wait_q;
   // inverse pattern outside the ack cycle, so stale data never matches
   assign mem_rdata = mem_addr ^ 32'ha5a5_0000 ^ {32{!mem_ack}};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 0;
         wait_q <= 0;
         wr_n <= 0;
         last_a <= 0;
         last_d <= 0;
      end else begin
         mem_ack <= 0;
         if (mem_req && !mem_ack) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q >= (slow ? 2'h3 : 2'h0)) begin
               mem_ack <= 1;
               wait_q <= 0;
            end
         end
         if (mem_ack && mem_we) begin
            wr_n <= wr_n + 16'h1;
            last_a <= mem_addr;
            last_d <= mem_wdata;
         end
      end
   end
endmodule // mem_model
`default_nettype wire

// ### tb/tb_top.sv
// bench: registers over ahb-lite, memory model as the far side
// assumes the design files and the memory model compiled before
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0;
   logic [1:0]  htrans = 0, mem_size;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, mem_addr, mem_wdata;
   logic [31:0] mem_rdata, last_a, last_d;
   logic        hreadyout, mem_req, mem_we, mem_ack;
   logic [4:0]  periph_rx_req = 0, periph_tx_req = 0, rx_ack;
   logic [3:0]  dma_irq;
   logic [15:0] wr_n, w0;
   int          n_fail = 0, tests_run = 0, cyc = 0;
   always #4 hclk = ~hclk;
   dma_controller dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp(), .mem_req, .mem_we, .mem_size, .mem_addr,
      .mem_wdata, .mem_rdata, .mem_ack, .periph_rx_req, .periph_tx_req,
      .periph_rx_ack(rx_ack), .periph_tx_ack(), .dma_irq);
   mem_model mem_u (.hclk, .hresetn, .slow, .mem_req, .mem_we, .mem_addr,
      .mem_wdata, .mem_ack, .mem_rdata, .wr_n, .last_a, .last_d);
   function automatic logic [31:0] pat(input logic [31:0] a);
      return a ^ 32'ha5a5_0000;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic prog(input logic [7:0] b, input logic [31:0] s, d,
                       input logic [15:0] len, input logic [31:0] c);
      w0 = wr_n;
      ahb(1, b, s);
      ahb(1, b + 8'h4, d);
      ahb(1, b + 8'h8, {16'h0, len});
      ahb(1, b + 8'hc, 0);
      ahb(1, b + 8'h10, c);
   endtask
   task automatic wait_off(input logic [7:0] b);
      do ahb(0, b + 8'h10, 0); while (r[0] !== 1'b0);
   endtask
   task automatic t_reset;
      ahb(0, 8'h80, 0);
      chk("route", 32'hff, r);
      ahb(0, 8'ha0, 0);
      chk("unmapped", 0, r);
   endtask
   // word copy, slow memory; wrap set but software trigger still stops
   task automatic t_word;
      slow <= 1;
      prog(8'h00, 32'h100, 32'h200, 2, 32'h0000_209d);
      wait_off(8'h00);
      chk("items", w0 + 3, wr_n);
      chk("dst", 32'h208, last_a);
      chk("data", pat(32'h108), last_d);
      chk("size", 2, mem_size);
      ahb(0, 8'h84, 0);
      chk("flag", 1, r);
      chk("irq", 1, dma_irq);
      ahb(1, 8'h84, 1);
      ahb(0, 8'h84, 0);
      chk("flag clr", 0, r);
      slow <= 0;
   endtask
   // byte fill under lock: fixed source, rising destination
   task automatic t_byte;
      prog(8'h20, 32'h300, 32'h400, 3, 32'h0000_1011);
      wait_off(8'h20);
      chk("b items", w0 + 4, wr_n);
      chk("b dst", 32'h403, last_a);
      chk("b data", pat(32'h300), last_d);
      chk("b size", 0, mem_size);
   endtask
   task automatic t_hw;
      ahb(1, 8'h80, 32'hf1);
      prog(8'h00, 32'h500, 32'h600, 0, 32'h0000_0035);
      repeat (20) @(posedge hclk);
      chk("no start", w0, wr_n);
      periph_rx_req[1] <= 1;
      for (int i = 0; i < 60 && rx_ack[1] !== 1'b1; i++) @(posedge hclk);
      chk("rx ack", 1, rx_ack[1]);
      periph_rx_req <= 0;
      wait_off(8'h00);
      chk("hw items", w0 + 1, wr_n);
   endtask
   // two channels held by freeze; on release the higher priority goes first
   task automatic t_freeze;
      ahb(1, 8'h88, 32'h10);
      ahb(0, 8'h90, 0);
      chk("frozen", 32'h10, r);
      prog(8'h40, 32'h700, 32'h800, 0, 32'h0000_0005);
      prog(8'h60, 32'h780, 32'h900, 0, 32'h0000_0105);
      repeat (20) @(posedge hclk);
      chk("held", w0, wr_n);
      ahb(1, 8'h8c, 32'h10);
      wait_off(8'h40);
      wait_off(8'h60);
      chk("thawed", w0 + 2, wr_n);
      chk("prio order", 32'h800, last_a);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // cut a hang short well past the expected run
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         stop_test;
      end
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1;
      t_reset;
      t_word;
      t_byte;
      t_hw;
      t_freeze;
      stop_test;
   end
endmodule // tb_top
`default_nettype wire
